// File: design/pbc_pkg.sv
package pbc_pkg;

  // Counter geometry
  localparam int PBC_WIDTH = 4;
  localparam logic [3:0] PBC_COUNT_RST = 4'h0;
  localparam logic [3:0] PBC_COUNT_MAX = 4'hF;
  localparam logic [3:0] PBC_COUNT_ONE = 4'h1;

  // Register byte offsets, one aligned word each
  localparam logic [7:0] PBC_OFF_CTRL = 8'h00;
  localparam logic [7:0] PBC_OFF_PRESET = 8'h04;
  localparam logic [7:0] PBC_OFF_LOAD = 8'h08;
  localparam logic [7:0] PBC_OFF_STATUS = 8'h0C;
  localparam logic [7:0] PBC_OFF_WRAPS = 8'h10;

  // Control register fields
  localparam int PBC_CTRL_SRC_BIT = 0;
  localparam int PBC_CTRL_GP_BIT = 1;
  localparam int PBC_CTRL_GC_BIT = 2;

  // Load register field
  localparam int PBC_LOAD_GO_BIT = 0;

  // Status register fields, count sits in bits 3..0
  localparam int PBC_ST_COUNT_LSB = 0;
  localparam int PBC_ST_CARRY_BIT = 4;
  localparam int PBC_ST_CLR_BIT = 5;

  // Values after reset
  localparam logic PBC_SRC_RST = 1'b0;
  localparam logic PBC_GP_RST = 1'b0;
  localparam logic PBC_GC_RST = 1'b0;
  localparam logic [3:0] PBC_PRESET_RST = 4'h0;
  localparam logic [15:0] PBC_WRAPS_RST = 16'h0000;
  localparam logic [15:0] PBC_WRAPS_ONE = 16'h0001;
  localparam logic [31:0] PBC_RDATA_RST = 32'h00000000;
  localparam logic [7:0] PBC_ADDR_RST = 8'h00;
  localparam logic [1:0] PBC_CLR_SYNC_RST = 2'h3;

  // Bus phase tracker, Gray coded along idle, wait, done
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_RDWAIT = 2'b01,
    PH_RDDONE = 2'b11,
    PH_WRITE = 2'b10
  } pbc_phase_t;

  // Whole state of the bus front end
  typedef struct packed {
    pbc_phase_t phase;
    logic [7:0] addr;
    logic addr_ok;
    logic [31:0] rdata;
    logic src_sw;
    logic gate_p;
    logic gate_c;
    logic [3:0] preset;
    logic load_go;
    logic [15:0] wraps;
    logic [1:0] clr_sync;
  } pbc_regs_t;

  // Whole state of the counting stage
  typedef struct packed {
    logic [3:0] count;
  } pbc_stage_t;

endpackage

// File: design/pbc_stage.sv
`timescale 1ns/10ps
// Four-bit presettable stage with asynchronous clear
module pbc_stage
  import pbc_pkg::*;
(
  input wire logic hclk,
  input wire logic clear_n,
  input wire logic load_n,
  input wire logic [3:0] load_data,
  input wire logic gate_p,
  input wire logic gate_c,
  output logic [3:0] count,
  output logic carry,
  output logic wrap
);

  pbc_stage_t s_q;
  pbc_stage_t s_d;

  // Next count: load beats the gates, both gates needed to count
  always_comb begin
    s_d = s_q;
    if (!load_n) begin
      s_d.count = load_data;
    end else if (gate_p && gate_c) begin
      s_d.count = s_q.count + PBC_COUNT_ONE;
    end else begin
      s_d.count = s_q.count;
    end
  end

  // Clear acts without the clock; all bits move on one edge
  always_ff @(posedge hclk or negedge clear_n) begin
    if (!clear_n) begin
      s_q.count <= PBC_COUNT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.count;
  // Carry ignores the parallel gate by design
  assign carry = (s_q.count == PBC_COUNT_MAX) && gate_c;
  // Next edge will roll the count over
  assign wrap = load_n && gate_p && carry;

endmodule // pbc_stage

// File: design/pbc_counter.sv
`timescale 1ns/10ps
// Behaviour
// - Holds a four-bit unsigned count, shown on four parallel outputs.
// - All count bits update together on the rising clock edge, except when cleared.
// - Outside software mode, preset low loads preset data on the next edge, enables ignored.
// - Clear low zeroes the count at once, overriding everything else.
// - With clear and preset idle, count increments when both gates high.
// - Carry high exactly while count is 15 and carry gate high.
// - Count wraps from 15 to 0 on the next enabled edge.
// - Gate and preset changes reach the count only at a clock edge; carry follows the carry gate at once.
module pbc_counter
  import pbc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic async_clear_n,
  input wire logic preset_load_n,
  input wire logic [3:0] preset_data,
  input wire logic count_gate_parallel,
  input wire logic count_gate_carry,
  output logic count_out0,
  output logic count_out1,
  output logic count_out2,
  output logic count_out3,
  output logic carry_out
);

  pbc_regs_t s_q;
  pbc_regs_t s_d;

  logic clear_n_w;
  logic load_n_w;
  logic [3:0] load_data_w;
  logic gate_p_w;
  logic gate_c_w;
  logic [3:0] count_w;
  logic carry_w;
  logic wrap_w;
  logic accept_w;

  // Word match on the low byte, upper address bits checked apart
  function automatic logic reg_hit(
    input logic [7:0] addr,
    input logic ok,
    input logic [7:0] off
  );
    reg_hit = ok && (addr[7:2] == off[7:2]);
  endfunction

  // Read value of one word; unmapped words read as zero
  function automatic logic [31:0] read_word(
    input logic [7:0] addr,
    input logic ok,
    input pbc_regs_t st,
    input logic [3:0] cnt,
    input logic cry,
    input logic clr_n
  );
    logic [31:0] w;
    w = 32'h00000000;
    if (reg_hit(addr, ok, PBC_OFF_CTRL)) begin
      w[PBC_CTRL_SRC_BIT] = st.src_sw;
      w[PBC_CTRL_GP_BIT] = st.gate_p;
      w[PBC_CTRL_GC_BIT] = st.gate_c;
    end else if (reg_hit(addr, ok, PBC_OFF_PRESET)) begin
      w[3:0] = st.preset;
    end else if (reg_hit(addr, ok, PBC_OFF_STATUS)) begin
      w[PBC_ST_COUNT_LSB +: PBC_WIDTH] = cnt;
      w[PBC_ST_CARRY_BIT] = cry;
      w[PBC_ST_CLR_BIT] = ~clr_n;
    end else if (reg_hit(addr, ok, PBC_OFF_WRAPS)) begin
      w[15:0] = st.wraps;
    end
    read_word = w;
  endfunction

  // Either reset empties the count; the clear pin needs no clock
  assign clear_n_w = hresetn & async_clear_n;

  // Software mode takes the gates from the control register and
  // masks the preset pin; a software load works in both modes
  assign gate_p_w = s_q.src_sw ? s_q.gate_p : count_gate_parallel;
  assign gate_c_w = s_q.src_sw ? s_q.gate_c : count_gate_carry;
  assign load_n_w = ~s_q.load_go & (s_q.src_sw | preset_load_n);
  assign load_data_w = s_q.load_go ? s_q.preset : preset_data;

  // The counting stage itself
  pbc_stage u_stage (
    .hclk(hclk),
    .clear_n(clear_n_w),
    .load_n(load_n_w),
    .load_data(load_data_w),
    .gate_p(gate_p_w),
    .gate_c(gate_c_w),
    .count(count_w),
    .carry(carry_w),
    .wrap(wrap_w)
  );

  // Bit weights 1, 2, 4, 8 in order
  assign count_out0 = count_w[0];
  assign count_out1 = count_w[1];
  assign count_out2 = count_w[2];
  assign count_out3 = count_w[3];
  assign carry_out = carry_w;

  // Reads stall one cycle so a write just ahead is already visible
  assign hreadyout = (s_q.phase != PH_RDWAIT);
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign accept_w = hsel && hready && htrans[1];

  // Bus front end and register updates
  always_comb begin
    s_d = s_q;
    s_d.load_go = 1'b0;
    // Clear pin is unclocked: two flops before the status word reads it
    s_d.clr_sync = {s_q.clr_sync[0], async_clear_n};
    case (s_q.phase)
      PH_RDWAIT: begin
        s_d.rdata = read_word(s_q.addr, s_q.addr_ok, s_q, count_w,
                              carry_w, s_q.clr_sync[1]);
        s_d.phase = PH_RDDONE;
      end
      PH_WRITE: begin
        if (reg_hit(s_q.addr, s_q.addr_ok, PBC_OFF_CTRL)) begin
          s_d.src_sw = hwdata[PBC_CTRL_SRC_BIT];
          s_d.gate_p = hwdata[PBC_CTRL_GP_BIT];
          s_d.gate_c = hwdata[PBC_CTRL_GC_BIT];
        end
        if (reg_hit(s_q.addr, s_q.addr_ok, PBC_OFF_PRESET)) begin
          s_d.preset = hwdata[3:0];
        end
        if (reg_hit(s_q.addr, s_q.addr_ok, PBC_OFF_LOAD)) begin
          s_d.load_go = hwdata[PBC_LOAD_GO_BIT];
        end
        if (reg_hit(s_q.addr, s_q.addr_ok, PBC_OFF_WRAPS)) begin
          s_d.wraps = PBC_WRAPS_RST;
        end
      end
      default: begin
        s_d.phase = s_q.phase;
      end
    endcase
    // A wrap in the clearing cycle still counts
    if (wrap_w) begin
      s_d.wraps = s_d.wraps + PBC_WRAPS_ONE;
    end
    // Take a new address phase; wait state cannot be left early
    if (accept_w) begin
      s_d.addr = haddr[7:0];
      s_d.addr_ok = (haddr[31:8] == 24'h000000);
      s_d.phase = hwrite ? PH_WRITE : PH_RDWAIT;
    end else if (s_q.phase != PH_RDWAIT) begin
      s_d.phase = PH_IDLE;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q.phase <= PH_IDLE;
      s_q.addr <= PBC_ADDR_RST;
      s_q.addr_ok <= 1'b0;
      s_q.rdata <= PBC_RDATA_RST;
      s_q.src_sw <= PBC_SRC_RST;
      s_q.gate_p <= PBC_GP_RST;
      s_q.gate_c <= PBC_GC_RST;
      s_q.preset <= PBC_PRESET_RST;
      s_q.load_go <= 1'b0;
      s_q.wraps <= PBC_WRAPS_RST;
      s_q.clr_sync <= PBC_CLR_SYNC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Transfer size is not checked: only word accesses are supported
  logic unused_w;
  assign unused_w = ^hsize;

endmodule // pbc_counter

// File: verif/pbc_far_stage.sv
`timescale 1ns/10ps
// Next cascaded stage: both of its gates come from the carry
module pbc_far_stage (
  input logic hclk,
  input logic clear_n,
  input logic carry_in,
  output logic [3:0] hi_q
);
  // Shares the clear so a cleared chain restarts at zero
  always_ff @(posedge hclk or negedge clear_n) begin
    if (!clear_n) hi_q <= 4'h0;
    else if (carry_in) hi_q <= hi_q + 4'h1;
  end
endmodule // pbc_far_stage

// File: verif/pbc_counter_sva.sv
`timescale 1ns/10ps
// Pin-mode checks; a mirror of CTRL and LOAD writes masks them
module pbc_counter_sva (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hready,
  input logic [31:0] haddr,
  input logic [31:0] hwdata,
  input logic hreadyout,
  input logic async_clear_n,
  input logic preset_load_n,
  input logic [3:0] preset_data,
  input logic count_gate_parallel,
  input logic count_gate_carry,
  input logic count_out0,
  input logic count_out1,
  input logic count_out2,
  input logic count_out3,
  input logic carry_out
);
  logic [3:0] cnt;
  logic run;
  logic both;
  logic take, wr_ctrl, wr_load, sw_q, gc_q, ld_q, pin;
  // Count gathered by bit weight
  assign cnt = {count_out3, count_out2, count_out1, count_out0};
  assign take = hsel && hready && htrans[1];
  // Preset and gate pins rule only outside software mode and software loads
  assign pin = !sw_q && !ld_q;
  assign run = async_clear_n && preset_load_n && pin;
  assign both = count_gate_parallel && count_gate_carry;
  // Mode mirror: a write lands at the edge after its address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctrl <= 1'b0;
      wr_load <= 1'b0;
      sw_q <= 1'b0;
      gc_q <= 1'b0;
      ld_q <= 1'b0;
    end else begin
      wr_ctrl <= take && hwrite && haddr == 32'h00000000;
      wr_load <= take && hwrite && haddr == 32'h00000008;
      ld_q <= wr_load && hwdata[0];
      if (wr_ctrl) begin
        sw_q <= hwdata[0];
        gc_q <= hwdata[2];
      end
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_clear_zero: assert property (
    !async_clear_n |-> cnt == 4'h0 && !carry_out) else $error("clear missed");
  a_preset_load: assert property (
    async_clear_n && !preset_load_n && pin ##1 async_clear_n
    |-> cnt == $past(preset_data)) else $error("preset missed");
  a_count_inc: assert property (
    run && both ##1 async_clear_n |-> cnt == $past(cnt) + 4'h1)
    else $error("count step wrong");
  a_count_hold: assert property (
    run && !both ##1 async_clear_n |-> $stable(cnt)) else $error("count moved");
  a_carry_match: assert property (
    carry_out == (cnt == 4'hF && (sw_q ? gc_q : count_gate_carry)))
    else $error("carry wrong");
  a_wrap_zero: assert property (
    run && both && cnt == 4'hF ##1 async_clear_n |-> cnt == 4'h0)
    else $error("no wrap");
  a_weight_one: assert property (
    run && both && cnt[0] == 1'b0 ##1 async_clear_n |-> count_out0)
    else $error("low bit wrong");
  a_read_wait: assert property (
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  cover property (carry_out);
  cover property (!preset_load_n);
  cover property (!async_clear_n);
  cover property (sw_q && carry_out);
endmodule // pbc_counter_sva
bind pbc_counter pbc_counter_sva i_sva (.*);

// File: verif/pbc_counter_tb.sv
`timescale 1ns/10ps
module pbc_counter_tb;
  import pbc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic async_clear_n, preset_load_n, count_gate_parallel, count_gate_carry;
  logic count_out0, count_out1, count_out2, count_out3, carry_out;
  logic [3:0] preset_data, cnt, hi;
  int errors, checks;
  // Rows: clear, load, data, gate p, gate c, expected count
  logic [11:0] rows [14] = '{12'h400, 12'hB3C, 12'hC3D, 12'hC3E, 12'hC3F,
    12'hC30, 12'hC31, 12'hC32, 12'hC12, 12'hC22, 12'hBDF, 12'hBCF, 12'h975,
    12'hABA};
  assign hready = hreadyout;
  assign cnt = {count_out3, count_out2, count_out1, count_out0};
  pbc_counter i_dut (.*);
  pbc_far_stage i_far (.hclk(hclk), .clear_n(async_clear_n),
    .carry_in(carry_out), .hi_q(hi));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One single transfer; only the watchdog bounds the waits
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk iff hreadyout);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk iff hreadyout);
    rd = hrdata;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Whole run is about 80 cycles
  initial begin
    repeat (2000) @(posedge hclk);
    errors++;
    end_of_test();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    {async_clear_n, preset_load_n, preset_data} = 6'h30;
    {count_gate_parallel, count_gate_carry} = 2'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // Every word reads zero after reset, unmapped one too
    for (int a = 0; a < 24; a += 4) begin
      xfer(1'b0, 8'(a), 32'h0);
      chk(rd, 32'h0);
      chk(hresp, 1'b0);
    end
    $display("reset values done");
    // Row i is sampled one edge on, checked at the negedge after
    for (int i = 0; i < 15; i++) begin
      if (i < 14) {async_clear_n, preset_load_n, preset_data,
        count_gate_parallel, count_gate_carry} <= rows[i][11:4];
      @(negedge hclk);
      if (i > 0) begin
        chk(cnt, rows[i - 1][3:0]);
        chk(carry_out, cnt == 4'hF && count_gate_carry);
      end
      @(posedge hclk);
    end
    chk(hi, 4'h2);
    $display("pin table done");
    preset_load_n <= 1'b1;
    count_gate_parallel <= 1'b0;
    xfer(1'b0, PBC_OFF_STATUS, 32'h0);
    chk(rd, 32'hA);
    xfer(1'b0, PBC_OFF_WRAPS, 32'h0);
    chk(rd, 32'h1);
    xfer(1'b1, PBC_OFF_WRAPS, 32'h0);
    xfer(1'b1, PBC_OFF_PRESET, 32'hFFFFFFF9);
    xfer(1'b1, 8'h14, 32'hFFFFFFFF);
    xfer(1'b0, PBC_OFF_WRAPS, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, PBC_OFF_PRESET, 32'h0);
    chk(rd, 32'h9);
    xfer(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    $display("bus done");
    // Clear must act between edges, not at the next one
    async_clear_n <= 1'b0;
    #1;
    chk(cnt, 4'h0);
    @(posedge hclk);
    xfer(1'b0, PBC_OFF_STATUS, 32'h0);
    chk(rd, 32'h20);
    async_clear_n <= 1'b1;
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, PBC_OFF_PRESET, 32'h0);
    chk(rd, 32'h0);
    $display("clear and reset done");
    // Software mode: preset pin masked, gates and load from registers
    xfer(1'b1, PBC_OFF_CTRL, 32'h1);
    {preset_load_n, preset_data, count_gate_carry} <= 6'h12;
    xfer(1'b1, PBC_OFF_PRESET, 32'hF);
    xfer(1'b0, PBC_OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b1, PBC_OFF_LOAD, 32'h1);
    xfer(1'b1, PBC_OFF_CTRL, 32'h5);
    xfer(1'b0, PBC_OFF_STATUS, 32'h0);
    chk(rd, 32'h1F);
    chk(carry_out, 1'b1);
    xfer(1'b0, PBC_OFF_CTRL, 32'h0);
    chk(rd, 32'h5);
    $display("software mode done");
    end_of_test();
  end
endmodule // pbc_counter_tb
